// *** hw/can_xcvr_pkg.sv ***
package can_xcvr_pkg;
  // transceiver mode field codes
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RXO  = 2'h2;
  localparam logic [1:0] MODE_NORM = 2'h3;

  // chip power mode codes on power_mode
  localparam logic [2:0] PM_NORMAL   = 3'h0;
  localparam logic [2:0] PM_STOP     = 3'h1;
  localparam logic [2:0] PM_SLEEP    = 3'h2;
  localparam logic [2:0] PM_RESTART  = 3'h3;
  localparam logic [2:0] PM_FAILSAFE = 3'h4;

  // register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // control field positions and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WD_BIT   = 2;
  localparam logic [1:0] MODE_RESET = MODE_OFF;
  localparam logic       WD_RESET   = 1'b0;

  // status field positions (write one to clear)
  localparam int ST_WAKE_BIT = 0;
  localparam int ST_FAIL_BIT = 1;
  localparam int ST_UV_BIT   = 2;

  // timing
  localparam int CLK_PERIOD_NS      = 8;
  localparam int WAKE_FILTER_MIN_NS = 500;
  localparam int WAKE_FILTER_MAX_NS = 1800;
  localparam int TX_TIMEOUT_US      = 4500;
  localparam int BUS_TIMEOUT_US     = 4500;
  // least time rounds up, longest time rounds down
  localparam int WAKE_MIN_CYC =
    (WAKE_FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_CYC = WAKE_FILTER_MAX_NS / CLK_PERIOD_NS;
  localparam int TX_TO_CYC_DEF =
    (TX_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_TO_CYC_DEF =
    (BUS_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // wake pattern detector states
  typedef enum logic [1:0] {W_IDLE, W_DOM1, W_REC, W_DOM2} wake_st_t;
endpackage

// *** hw/can_xcvr_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - receive-only: driver off, set in Normal/Stop
// - wake-capable selectable; forced on Fail-Safe entry
// - after wake pattern, receive pin low
// - pattern: two dominant phases within filter window
// - mode field still reads wake-capable after wake
// - mode toggle through other mode rearms
// - rearm on Stop/Fail-Safe entry, Stop re-command
// - bus wake flag cleared by toggling mode
// - Stop/Normal wake: interrupt low, status, receive low
// - no automatic Stop to Normal after wake
// - Stop wake enables watchdog if configured
// - Sleep wake: restart request, no interrupt
// - Fail-Safe wake: restart, supply ramp; Restart wake: flag only
// - transmit dominant timeout forces recessive, flags
// - transmitter resumes once transmit input released
// - bus dominant timeout sets fail flag
// - supply undervoltage flags and blocks transmitter
// - supply recovery resumes, mode bits untouched
// - wake-capable monitors supply only after wake
// - receiver level shown on receive output in normal/receive-only
// - off after reset; wakes ignored when off
// - normal mode only in chip Normal mode
module can_xcvr_ctrl
  import can_xcvr_pkg::*;
#(
  parameter int TX_TO_CYC  = TX_TO_CYC_DEF,
  parameter int BUS_TO_CYC = BUS_TO_CYC_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [2:0]  power_mode,
  input  wire logic        stop_recommand,
  input  wire logic        bus_dominant_in,
  input  wire logic        can_transmit_in,
  input  wire logic        transceiver_supply_ok,
  output logic             can_receive_out,
  output logic             bus_drive_dominant,
  output logic             irq_n,
  output logic             restart_request,
  output logic             main_supply_ramp,
  output logic             watchdog_enable
);

  // whole module state, one register
  typedef struct packed {
    logic [1:0]  s_bus;      // bus level synchroniser
    logic [1:0]  s_tx;       // transmit pin synchroniser
    logic [1:0]  s_sup;      // supply-ok synchroniser
    logic [1:0]  mode;       // transceiver mode field
    logic        wd_cfg;     // watchdog on bus wake
    logic        armed;      // wake detection enabled
    logic        woke;       // pattern seen in this mode
    logic        wake_flag;  // bus wake / wake source
    logic        fail_flag;  // transceiver fail
    logic        uv_flag;    // supply low, sticky
    logic        irq_pend;   // interrupt pending
    logic        tx_blocked; // dominant timeout lockout
    logic        uv_active;  // live undervoltage
    wake_st_t    wst;        // pattern detector state
    logic [11:0] wcnt;       // wake phase length
    logic [19:0] tcnt;       // transmit dominant length
    logic [19:0] bcnt;       // bus dominant length
    logic [2:0]  pm_prev;    // power mode, last cycle
    logic        ack;        // bus answer cycle
    logic [31:0] rdata;      // read data
    logic        restart_p;  // restart request pulse
    logic        ramp_p;     // supply ramp pulse
    logic        wden_p;     // watchdog enable pulse
  } state_t;

  state_t st_reg;   // registered state
  state_t st_next;  // next state

  logic bus_dom;    // synchronised bus dominant
  logic tx_dom;     // synchronised transmit dominant
  logic sup_ok;     // synchronised supply ok
  logic req;        // bus request present
  logic wr_ctrl;    // accepted control write
  logic wr_stat;    // accepted status write
  logic wake_det;   // pattern completed this cycle
  logic monitor;    // supply monitoring active
  logic [1:0] req_mode; // requested mode code
  logic mode_ok;    // requested mode allowed now
  logic rearm;      // power mode rearm event

  assign bus_dom = st_reg.s_bus[1];
  assign tx_dom  = st_reg.s_tx[1];
  assign sup_ok  = st_reg.s_sup[1];
  assign req     = avs_read | avs_write;
  // one wait state: answer on the cycle after the request appears
  assign avs_waitrequest = req & ~st_reg.ack;
  assign wr_ctrl = avs_write & st_reg.ack & (avs_address == CTRL_OFS);
  assign wr_stat = avs_write & st_reg.ack & (avs_address == STATUS_OFS);
  assign req_mode = avs_writedata[CTRL_MODE_LSB +: 2];

  // mode selection allowed per chip power mode
  always_comb begin
    mode_ok = 1'b0;
    case (req_mode)
      MODE_OFF:  mode_ok = 1'b1;
      MODE_RXO:  mode_ok = (power_mode == PM_NORMAL) ||
                           (power_mode == PM_STOP);
      MODE_WAKE: mode_ok = (power_mode == PM_NORMAL) ||
                           (power_mode == PM_STOP) ||
                           (power_mode == PM_SLEEP) ||
                           (power_mode == PM_RESTART);
      MODE_NORM: mode_ok = (power_mode == PM_NORMAL);
      default:   mode_ok = 1'b0;
    endcase
  end

  // rearm on entering Stop or Fail-Safe, or Stop commanded again
  assign rearm = ((power_mode == PM_STOP) &&
                  (st_reg.pm_prev != PM_STOP)) ||
                 ((power_mode == PM_FAILSAFE) &&
                  (st_reg.pm_prev != PM_FAILSAFE)) ||
                 (stop_recommand && (power_mode == PM_STOP));

  // pattern completes when the second dominant phase is long enough
  assign wake_det = (st_reg.wst == W_DOM2) && bus_dom &&
                    ({20'h0, st_reg.wcnt} == 32'(WAKE_MIN_CYC - 1)) &&
                    (st_reg.mode == MODE_WAKE) && st_reg.armed;

  // supply watched in normal/receive-only, or wake-capable after wake
  assign monitor = (st_reg.mode == MODE_NORM) ||
                   (st_reg.mode == MODE_RXO) ||
                   ((st_reg.mode == MODE_WAKE) && st_reg.woke);

  // next-state logic
  always_comb begin
    st_next = st_reg;
    // synchronisers: first stage feeds only the second
    st_next.s_bus = {st_reg.s_bus[0], bus_dominant_in};
    st_next.s_tx  = {st_reg.s_tx[0], ~can_transmit_in};
    st_next.s_sup = {st_reg.s_sup[0], transceiver_supply_ok};
    st_next.pm_prev   = power_mode;
    st_next.ack       = req & ~st_reg.ack;
    st_next.restart_p = 1'b0;
    st_next.ramp_p    = 1'b0;
    st_next.wden_p    = 1'b0;

    // register read, sampled as the answer is formed
    if (req & ~st_reg.ack) begin
      st_next.rdata = 32'h0;  // unmapped reads as zero
      if (avs_address == CTRL_OFS) begin
        st_next.rdata[CTRL_MODE_LSB +: 2] = st_reg.mode;
        st_next.rdata[CTRL_WD_BIT] = st_reg.wd_cfg;
      end else if (avs_address == STATUS_OFS) begin
        st_next.rdata[ST_WAKE_BIT] = st_reg.wake_flag;
        st_next.rdata[ST_FAIL_BIT] = st_reg.fail_flag;
        st_next.rdata[ST_UV_BIT]   = st_reg.uv_flag;
      end
    end

    // control write; a mode not allowed now leaves the field as is
    if (wr_ctrl) begin
      st_next.wd_cfg = avs_writedata[CTRL_WD_BIT];
      if (mode_ok) begin
        st_next.mode = req_mode;
      end
    end
    // fail-safe entry forces wake-capable
    if ((power_mode == PM_FAILSAFE) &&
        (st_reg.pm_prev != PM_FAILSAFE)) begin
      st_next.mode = MODE_WAKE;
    end
    // any mode change ends the woken state; a change into wake-capable rearms detection
    if (st_next.mode != st_reg.mode) begin
      st_next.woke = 1'b0;
      st_next.armed = (st_next.mode == MODE_WAKE);
      st_next.wake_flag = 1'b0;
    end
    if (rearm) begin
      st_next.armed = 1'b1;
      st_next.woke  = 1'b0;
    end

    // status clear by writing one
    if (wr_stat) begin
      if (avs_writedata[ST_WAKE_BIT]) begin
        st_next.wake_flag = 1'b0;
        st_next.irq_pend  = 1'b0;
      end
      if (avs_writedata[ST_FAIL_BIT]) st_next.fail_flag = 1'b0;
      if (avs_writedata[ST_UV_BIT])   st_next.uv_flag   = 1'b0;
    end

    // wake pattern detector, idle unless armed in wake-capable
    if ((st_next.mode != MODE_WAKE) || !st_reg.armed) begin
      st_next.wst  = W_IDLE;
      st_next.wcnt = 12'h0;
    end else begin
      case (st_reg.wst)
        W_IDLE: begin
          st_next.wcnt = 12'h0;
          if (bus_dom) begin
            st_next.wst = W_DOM1;
          end
        end
        W_DOM1, W_REC, W_DOM2: begin
          // phase level: dominant in DOM states, recessive in REC
          if (bus_dom == (st_reg.wst != W_REC)) begin
            if ({20'h0, st_reg.wcnt} >= 32'(WAKE_MAX_CYC - 1)) begin
              st_next.wst  = W_IDLE;  // too long
              st_next.wcnt = 12'h0;
            end else begin
              st_next.wcnt = st_reg.wcnt + 12'h1;
            end
          end else if ({20'h0, st_reg.wcnt} >= 32'(WAKE_MIN_CYC - 1)) begin
            // phase ended in window: go on to the next phase
            st_next.wst  = (st_reg.wst == W_DOM1) ? W_REC : W_DOM1;
            st_next.wcnt = 12'h0;
            if (st_reg.wst == W_REC) begin
              st_next.wst = W_DOM2;
            end
          end else begin
            // too short; a short dominant glitch restarts search
            st_next.wst  = bus_dom ? W_DOM1 : W_IDLE;
            st_next.wcnt = 12'h0;
          end
        end
        default: st_next.wst = W_IDLE;
      endcase
    end

    // actions of a detected wake, per chip power mode
    if (wake_det) begin
      st_next.wst = W_IDLE;
      st_next.woke = 1'b1;
      st_next.armed = 1'b0;
      st_next.wake_flag = 1'b1;
      case (power_mode)
        PM_NORMAL: st_next.irq_pend = 1'b1;
        PM_STOP: begin
          st_next.irq_pend = 1'b1;
          st_next.wden_p = st_reg.wd_cfg;
        end
        PM_SLEEP, PM_FAILSAFE: begin
          st_next.restart_p = 1'b1;
          st_next.ramp_p    = 1'b1;
        end
        default: st_next.restart_p = 1'b0;  // restart stays put
      endcase
    end

    // transmit dominant timeout, counted only in normal mode
    if ((st_reg.mode == MODE_NORM) && tx_dom) begin
      if ({12'h0, st_reg.tcnt} >= 32'(TX_TO_CYC)) begin
        st_next.tx_blocked = 1'b1;
        st_next.fail_flag  = 1'b1;
      end else begin
        st_next.tcnt = st_reg.tcnt + 20'h1;
      end
    end else begin
      st_next.tcnt = 20'h0;
      st_next.tx_blocked = 1'b0;
    end

    // bus clamped dominant in normal or receive-only
    if (((st_reg.mode == MODE_NORM) || (st_reg.mode == MODE_RXO)) &&
        bus_dom) begin
      if ({12'h0, st_reg.bcnt} >= 32'(BUS_TO_CYC)) begin
        st_next.fail_flag = 1'b1;
      end else begin
        st_next.bcnt = st_reg.bcnt + 20'h1;
      end
    end else begin
      st_next.bcnt = 20'h0;
    end

    // supply undervoltage; recovery leaves the mode bits alone
    st_next.uv_active = monitor & ~sup_ok;
    if (monitor & ~sup_ok) begin
      st_next.uv_flag = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{
        s_bus: 2'h0, s_tx: 2'h0, s_sup: 2'h0,
        mode: MODE_RESET, wd_cfg: WD_RESET,
        armed: 1'b0, woke: 1'b0, wake_flag: 1'b0,
        fail_flag: 1'b0, uv_flag: 1'b0, irq_pend: 1'b0,
        tx_blocked: 1'b0, uv_active: 1'b0, wst: W_IDLE,
        wcnt: 12'h0, tcnt: 20'h0, bcnt: 20'h0,
        pm_prev: PM_NORMAL, ack: 1'b0, rdata: 32'h0,
        restart_p: 1'b0, ramp_p: 1'b0, wden_p: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  always_comb begin
    case (st_reg.mode)
      MODE_NORM, MODE_RXO: can_receive_out = ~bus_dom;
      MODE_WAKE: can_receive_out = ~st_reg.woke;
      default:   can_receive_out = 1'b1;
    endcase
  end
  // driver only in normal mode during chip Normal, without lockouts
  assign bus_drive_dominant = (st_reg.mode == MODE_NORM) &&
                              (power_mode == PM_NORMAL) && tx_dom &&
                              !st_reg.tx_blocked &&
                              !st_reg.uv_active;
  assign irq_n           = ~st_reg.irq_pend;
  assign restart_request = st_reg.restart_p;
  assign main_supply_ramp = st_reg.ramp_p;
  assign watchdog_enable = st_reg.wden_p;
  assign avs_readdata    = st_reg.rdata;

  property p_rxd_woke;
    @(posedge sys_clk) disable iff (sys_rst)
    wake_det |=> !can_receive_out [*2];
  endproperty
  a_rxd_woke: assert property (p_rxd_woke)
    else $error("receive output not low after wake");

  property p_rxo_gate;
    @(posedge sys_clk) disable iff (sys_rst)
    (wr_ctrl && req_mode == MODE_RXO && power_mode == PM_SLEEP &&
     st_reg.pm_prev == PM_SLEEP) |=> $stable(st_reg.mode);
  endproperty
  a_rxo_gate: assert property (p_rxo_gate)
    else $error("receive-only taken outside Normal/Stop");

  property p_mode_read;
    @(posedge sys_clk) disable iff (sys_rst)
    st_reg.woke |-> st_reg.mode == MODE_WAKE;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("woken with mode not wake-capable");

  property p_irq_stop;
    @(posedge sys_clk) disable iff (sys_rst)
    (wake_det && power_mode == PM_STOP && !wr_stat)
      |=> !irq_n && st_reg.wake_flag;
  endproperty
  a_irq_stop: assert property (p_irq_stop)
    else $error("stop wake not signalled");

  property p_sleep_wake;
    @(posedge sys_clk) disable iff (sys_rst)
    (wake_det && power_mode == PM_SLEEP && irq_n)
      |=> restart_request && main_supply_ramp && irq_n;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep wake action wrong");

  property p_tx_lock;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(st_reg.tx_blocked) |-> st_reg.fail_flag && !bus_drive_dominant;
  endproperty
  a_tx_lock: assert property (p_tx_lock)
    else $error("transmit timeout not enforced");

  property p_tx_resume;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_reg.tx_blocked && !tx_dom) |=> !st_reg.tx_blocked;
  endproperty
  a_tx_resume: assert property (p_tx_resume)
    else $error("transmitter not released");

  property p_off_ignore;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_reg.mode == MODE_OFF) |-> !wake_det && st_reg.wst == W_IDLE;
  endproperty
  a_off_ignore: assert property (p_off_ignore)
    else $error("wake seen in off mode");

  property p_norm_only;
    @(posedge sys_clk) disable iff (sys_rst)
    bus_drive_dominant |-> power_mode == PM_NORMAL &&
                           st_reg.mode == MODE_NORM && !st_reg.uv_active;
  endproperty
  a_norm_only: assert property (p_norm_only)
    else $error("driver active outside normal mode");

  property p_uv_flag;
    @(posedge sys_clk) disable iff (sys_rst)
    (monitor && !sup_ok) |=> st_reg.uv_flag && st_reg.uv_active;
  endproperty
  a_uv_flag: assert property (p_uv_flag)
    else $error("undervoltage not flagged");

endmodule // can_xcvr_ctrl

// *** verif/can_bus_model.sv ***
`timescale 1ns/1ps
// far side: bus nodes sending wake patterns, plus the controller pins
module can_bus_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       wake_go,
  input  wire logic [7:0] dom_len,
  input  wire logic [7:0] rec_len,
  input  wire logic       far_hold,
  input  wire logic       tx_dom,
  input  wire logic       supply_low,
  input  wire logic       bus_drive_dominant,
  output logic            bus_dominant_in,
  output logic            can_transmit_in,
  output logic            transceiver_supply_ok,
  output logic            busy
);
  logic [1:0] phase_reg; // 0 idle, 1 dom, 2 rec, 3 dom
  logic [7:0] cnt_reg;   // cycles left in phase

  // pattern sequencer: dom, rec, dom, then back to idle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= 2'h0;
      cnt_reg   <= 8'h00;
    end else if (phase_reg == 2'h0) begin
      if (wake_go) begin
        phase_reg <= 2'h1;
        cnt_reg   <= dom_len;
      end
    end else if (cnt_reg == 8'h01) begin
      // wrap from 3 to idle
      phase_reg <= phase_reg + 2'h1;
      cnt_reg   <= (phase_reg == 2'h1) ? rec_len : dom_len;
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // wired bus: own driver or any far node makes it dominant
  assign bus_dominant_in = bus_drive_dominant | far_hold |
                           phase_reg[0];
  assign can_transmit_in = ~tx_dom;  // recessive unless asked
  assign transceiver_supply_ok = ~supply_low; // powered first
  assign busy = (phase_reg != 2'h0);
endmodule // can_bus_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  import can_xcvr_pkg::*;
  logic        sys_clk, sys_rst, avs_read, avs_write, stop_recommand;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, exp_v;
  logic [2:0]  power_mode;
  logic        avs_waitrequest, bus_dominant_in, can_transmit_in;
  logic        transceiver_supply_ok, can_receive_out, bus_drive_dominant;
  logic        irq_n, restart_request, main_supply_ramp, watchdog_enable;
  logic        wake_go, far_hold, tx_dom, supply_low, busy;
  logic [7:0]  dom_len, rec_len, dom_lo;  // dom_lo: shortest dominant
  logic [31:0] exp_q[$];  // expected read data, oldest first
  int          err_total, tests_run, rst_cnt, ramp_cnt, wd_cnt;
  int          seed = 32'h1f62;

  // short timeouts keep the run brief
  can_xcvr_ctrl #(.TX_TO_CYC(40), .BUS_TO_CYC(40)) u_can_xcvr_ctrl (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_mode(power_mode),
    .stop_recommand(stop_recommand), .bus_dominant_in(bus_dominant_in),
    .can_transmit_in(can_transmit_in),
    .transceiver_supply_ok(transceiver_supply_ok),
    .can_receive_out(can_receive_out),
    .bus_drive_dominant(bus_drive_dominant), .irq_n(irq_n),
    .restart_request(restart_request),
    .main_supply_ramp(main_supply_ramp),
    .watchdog_enable(watchdog_enable));

  can_bus_model u_can_bus_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wake_go(wake_go),
    .dom_len(dom_len), .rec_len(rec_len), .far_hold(far_hold),
    .tx_dom(tx_dom), .supply_low(supply_low),
    .bus_drive_dominant(bus_drive_dominant),
    .bus_dominant_in(bus_dominant_in), .can_transmit_in(can_transmit_in),
    .transceiver_supply_ok(transceiver_supply_ok), .busy(busy));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // avalon write: held until waitrequest seen low at an edge
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest);
    avs_write <= 1'b0;
    // the write lands at that edge; let it show before any check
    @(posedge sys_clk);
  endtask

  // avalon read: expectation queued, monitor compares
  task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest);
    avs_read <= 1'b0;
  endtask

  // random phase lengths stay inside the filter window while dom_lo is 70
  task automatic send_wake();
    @(posedge sys_clk);
    dom_len <= dom_lo + 8'($random(seed) & 31);
    rec_len <= 8'd70 + 8'($random(seed) & 63);
    wake_go <= 1'b1;
    @(posedge sys_clk);
    wake_go <= 1'b0;
    wait_cyc(2);
    for (int i = 0; i < 1000 && busy; i++) @(posedge sys_clk);
    wait_cyc(4);
  endtask

  // read-data monitor: pre-edge values are the answer
  always @(posedge sys_clk) begin
    if (avs_read && !avs_waitrequest) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxxxxxx;
      chk("readdata", exp_v, avs_readdata);
    end
  end

  // count one-cycle pulses
  always @(posedge sys_clk) begin
    if (restart_request) rst_cnt++;
    if (main_supply_ramp) ramp_cnt++;
    if (watchdog_enable) wd_cnt++;
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, stop_recommand, wake_go} = 4'h0;
    {far_hold, tx_dom, supply_low} = 3'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    power_mode = PM_NORMAL;
    dom_len = 8'h46;
    dom_lo = 8'd70;
    rec_len = 8'h46;
    wait_cyc(12);
    sys_rst <= 1'b0;
    bus_rd(CTRL_OFS, 32'h0);
    bus_rd(STATUS_OFS, 32'h0);
    bus_rd(4'h8, 32'h0);
    send_wake();
    chk("rx_off", 1, can_receive_out);
    bus_wr(CTRL_OFS, 32'h5);
    send_wake();
    chk("rx_wake", 0, can_receive_out);
    chk("irq_norm", 0, irq_n);
    chk("wd_norm", 0, wd_cnt);
    bus_rd(CTRL_OFS, 32'h5);
    bus_rd(STATUS_OFS, 32'h1);
    bus_wr(CTRL_OFS, 32'h0);
    bus_wr(CTRL_OFS, 32'h5);
    bus_wr(STATUS_OFS, 32'h7);
    chk("rx_rearm", 1, can_receive_out);
    chk("irq_clr", 1, irq_n);
    // dominant phases shorter than the filter must not wake
    dom_lo = 8'd10;
    send_wake();
    dom_lo = 8'd70;
    chk("rx_short", 1, can_receive_out);
    chk("irq_short", 1, irq_n);
    power_mode <= PM_STOP;
    send_wake();
    chk("wd_stop", 1, wd_cnt);
    chk("irq_stop", 0, irq_n);
    chk("stay_stop", 0, rst_cnt);
    @(posedge sys_clk);
    stop_recommand <= 1'b1;
    @(posedge sys_clk);
    stop_recommand <= 1'b0;
    wait_cyc(3);
    chk("rx_restop", 1, can_receive_out);
    bus_wr(STATUS_OFS, 32'h7);
    power_mode <= PM_SLEEP;
    send_wake();
    chk("rst_sleep", 1, rst_cnt);
    chk("ramp_sleep", 1, ramp_cnt);
    chk("irq_sleep", 1, irq_n);
    chk("rx_sleep", 0, can_receive_out);
    power_mode <= PM_FAILSAFE;
    wait_cyc(4);
    chk("rx_fs", 1, can_receive_out);
    send_wake();
    chk("rst_fs", 2, rst_cnt);
    chk("ramp_fs", 2, ramp_cnt);
    bus_rd(CTRL_OFS, 32'h5);
    power_mode <= PM_RESTART;
    bus_wr(CTRL_OFS, 32'h0);
    bus_wr(CTRL_OFS, 32'h1);
    // supply dip before the wake is not watched in wake-capable mode
    supply_low <= 1'b1;
    wait_cyc(6);
    supply_low <= 1'b0;
    send_wake();
    chk("rx_rs", 0, can_receive_out);
    chk("irq_rs", 1, irq_n);
    bus_rd(STATUS_OFS, 32'h1);
    bus_wr(STATUS_OFS, 32'h7);
    power_mode <= PM_NORMAL;
    bus_wr(CTRL_OFS, 32'h3);
    tx_dom <= 1'b1;
    wait_cyc(6);
    chk("drv_on", 1, bus_drive_dominant);
    chk("rx_echo", 0, can_receive_out);
    wait_cyc(60);
    chk("drv_to", 0, bus_drive_dominant);
    bus_rd(CTRL_OFS, 32'h3);
    bus_rd(STATUS_OFS, 32'h2);
    tx_dom <= 1'b0;
    wait_cyc(4);
    tx_dom <= 1'b1;
    wait_cyc(5);
    chk("drv_back", 1, bus_drive_dominant);
    tx_dom <= 1'b0;
    bus_wr(STATUS_OFS, 32'h7);
    bus_wr(CTRL_OFS, 32'h2);
    tx_dom <= 1'b1;
    far_hold <= 1'b1;
    wait_cyc(6);
    chk("drv_rxo", 0, bus_drive_dominant);
    chk("rx_rxo", 0, can_receive_out);
    tx_dom <= 1'b0;
    wait_cyc(56);
    far_hold <= 1'b0;
    bus_rd(STATUS_OFS, 32'h2);
    bus_rd(CTRL_OFS, 32'h2);
    bus_wr(STATUS_OFS, 32'h7);
    bus_wr(CTRL_OFS, 32'h3);
    supply_low <= 1'b1;
    tx_dom <= 1'b1;
    wait_cyc(6);
    chk("drv_uv", 0, bus_drive_dominant);
    supply_low <= 1'b0;
    wait_cyc(6);
    chk("drv_ok", 1, bus_drive_dominant);
    tx_dom <= 1'b0;
    bus_rd(STATUS_OFS, 32'h4);
    bus_rd(CTRL_OFS, 32'h3);
    bus_wr(CTRL_OFS, 32'h0);
    power_mode <= PM_SLEEP;
    bus_wr(CTRL_OFS, 32'h2);
    bus_wr(CTRL_OFS, 32'h3);
    bus_rd(CTRL_OFS, 32'h0);
    wait_cyc(4);
    final_report();
  end
endmodule // tb
